// ==== design/trig_ref_pkg.sv ====
// Purpose: Shared constants and types for the trigger port and reference select block.
// Assumes: 25 MHz system clock, synchronous active-high reset.
// Notes: Register offsets are byte addresses on the plain register port.
//
// What this block does
// - Positive polarity reads high as 1, low as 0; negative inverts it.
// - Rising slope triggers only on low-to-high; falling slope only on high-to-low.
// - Port is input with external source, drives internal trigger with internal source.
// - Rising mode drives high for 1, falling mode drives low for 1, closed drives nothing.
// - In burst function the output value is 1 exactly while a burst runs.
// - Sweep with internal source: 1 at sweep start for half the sweep time.
// - Sequence with internal source: 1 at sequence start for one step dwell.
// - Sync pulse output stays disabled after power-on until software enables it.
// - A lockable external reference is selected automatically and flagged active.
// - Out-of-range reference: internal clock, invalid flag, keep retrying detection.
// - Removal of the reference is signalled, indication cleared, internal clock used.
// - Reference output always carries the internal 10 MHz reference.
package trig_ref_pkg;

  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned TICK_NS = 1000;
  localparam int unsigned TICK_CYCLES = (CLK_HZ / 1_000_000) * TICK_NS / 1000;
  localparam int unsigned REF_HZ = 10_000_000;
  localparam int unsigned REF_WINDOW_NS = 100_000;
  localparam int unsigned REF_WINDOW_CYCLES = (CLK_HZ / 1_000_000) * REF_WINDOW_NS / 1000;
  localparam int unsigned REF_EDGES_NOMINAL = (REF_HZ / 1_000_000) * REF_WINDOW_NS / 1000;
  localparam int unsigned LOCK_TOL_EDGES = 10;
  localparam int unsigned PRESENT_MIN_EDGES = 16;

  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 32;
  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_SWEEP_TIME = 4'h4;
  localparam logic [3:0] OFF_DWELL_TIME = 4'h8;
  localparam logic [3:0] OFF_STATUS = 4'hC;

  localparam int unsigned CTRL_SRC_INT_BIT = 0;
  localparam int unsigned CTRL_POL_NEG_BIT = 1;
  localparam int unsigned CTRL_SLOPE_FALL_BIT = 2;
  localparam int unsigned CTRL_TOM_LSB = 3;
  localparam int unsigned CTRL_FUNC_LSB = 5;
  localparam int unsigned CTRL_SYNC_EN_BIT = 7;
  localparam int unsigned CTRL_USED_W = 8;

  localparam int unsigned ST_EXT_ACTIVE_BIT = 0;
  localparam int unsigned ST_INVALID_BIT = 1;
  localparam int unsigned ST_REMOVED_BIT = 2;
  localparam int unsigned ST_TRIG_OUT_BIT = 3;
  localparam int unsigned ST_TRIG_LEVEL_BIT = 4;
  localparam int unsigned ST_TRIG_EDGE_BIT = 5;

  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] SWEEP_TIME_RESET = 32'h004C_4B40;
  localparam logic [31:0] DWELL_TIME_RESET = 32'h000F_4240;

  typedef enum logic [1:0] {
    TOM_CLOSED = 2'h0,
    TOM_RISING = 2'h1,
    TOM_FALLING = 2'h2
  } trigger_output_mode_t;

  typedef enum logic [1:0] {
    FN_BURST = 2'h0,
    FN_SWEEP = 2'h1,
    FN_SEQUENCE = 2'h2
  } gen_function_t;

  typedef enum logic [2:0] {
    REF_NONE = 3'b001,
    REF_EXT = 3'b010,
    REF_BAD = 3'b100
  } ref_state_t;

endpackage

// ==== design/ref_status_if.sv ====
// Purpose: Carries reference measurement results from the monitor to the core.
// Assumes: Both ends run on the system clock.
// Notes: window_done is a one-cycle pulse; present and in_range are levels.
`timescale 1ns/1ps
`default_nettype none
interface ref_status_if;
  logic present;
  logic in_range;
  logic window_done;
  modport mon (output present, output in_range, output window_done);
  modport core (input present, input in_range, input window_done);
endinterface
`default_nettype wire

// ==== design/ref_freq_monitor.sv ====
// Purpose: Counts reference clock edges over a fixed window, judging presence and range.
// Assumes: Reference input sampled by the 25 MHz clock; 10 MHz is below half that rate.
// Notes: Measurement repeats every window so a bad reference is retried forever.
`timescale 1ns/1ps
`default_nettype none
module ref_freq_monitor #(
  parameter int unsigned WINDOW_CYCLES = trig_ref_pkg::REF_WINDOW_CYCLES,
  parameter int unsigned LOCK_MIN = trig_ref_pkg::REF_EDGES_NOMINAL - trig_ref_pkg::LOCK_TOL_EDGES,
  parameter int unsigned LOCK_MAX = trig_ref_pkg::REF_EDGES_NOMINAL + trig_ref_pkg::LOCK_TOL_EDGES,
  parameter int unsigned PRESENT_MIN = trig_ref_pkg::PRESENT_MIN_EDGES
) (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic ref_level_i,
  ref_status_if.mon st
);
  import trig_ref_pkg::*;

  logic ref_meta_q, ref_sync_q, ref_prev_q;
  logic [15:0] win_q;
  logic [15:0] edges_q;
  logic win_end;

  assign win_end = (win_q == 16'(WINDOW_CYCLES - 1));

  always_ff @(posedge clock_i) begin
    ref_meta_q <= ref_level_i;
    ref_sync_q <= ref_meta_q;
    ref_prev_q <= ref_sync_q;
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      win_q <= 16'h0000;
      edges_q <= 16'h0000;
    end else if (win_end) begin
      win_q <= 16'h0000;
      edges_q <= 16'h0000;
    end else begin
      win_q <= win_q + 16'h0001;
      if (ref_sync_q && !ref_prev_q && edges_q != 16'hFFFF) begin
        edges_q <= edges_q + 16'h0001;
      end
    end
  end

  // A fresh verdict after every window keeps lock detection retrying.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      st.present <= 1'b0;
      st.in_range <= 1'b0;
      st.window_done <= 1'b0;
    end else begin
      st.window_done <= win_end;
      if (win_end) begin
        st.present <= (edges_q >= 16'(PRESENT_MIN));
        st.in_range <= (edges_q >= 16'(LOCK_MIN)) && (edges_q <= 16'(LOCK_MAX));
      end
    end
  end
endmodule
`default_nettype wire

// ==== design/trig_ref_top.sv ====
// Purpose: Trigger in/out port logic and external reference selection.
// Assumes: All inputs synchronous to clock_i except the trigger and reference pins.
// Notes: Trigger output timers count in 1 us ticks from a clock divider.
//
// Implementation choices: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module trig_ref_top #(
  parameter int unsigned TIME_W = 32,
  parameter int unsigned REF_WINDOW = trig_ref_pkg::REF_WINDOW_CYCLES
) (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic [trig_ref_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [trig_ref_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [trig_ref_pkg::DATA_W-1:0] reg_rdata_o,
  input wire logic burst_active_i,
  input wire logic sweep_start_i,
  input wire logic seq_start_i,
  input wire logic trig_pin_i,
  output logic trig_pin_o,
  output logic trig_pin_oe_o,
  output logic trig_event_o,
  input wire logic reference_clock_input_i,
  output logic ref_sel_ext_o,
  output logic ext_ref_active_o,
  output logic ref_invalid_o,
  output logic ref_removed_o,
  output logic reference_clock_output_en_o,
  output logic sync_out_en_o
);
  import trig_ref_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Decoding helpers.

  function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [3:0] off);
    hit = (addr == off);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Register file.

  logic [CTRL_USED_W-1:0] ctrl_q;
  logic [TIME_W-1:0] sweep_time_q;
  logic [TIME_W-1:0] dwell_time_q;
  logic removed_q;
  logic edge_seen_q;
  logic [DATA_W-1:0] rdata_d;

  logic src_internal;
  logic pol_negative;
  logic slope_falling;
  trigger_output_mode_t out_mode;
  gen_function_t gen_fn;

  assign src_internal = ctrl_q[CTRL_SRC_INT_BIT];
  assign pol_negative = ctrl_q[CTRL_POL_NEG_BIT];
  assign slope_falling = ctrl_q[CTRL_SLOPE_FALL_BIT];
  assign out_mode = trigger_output_mode_t'(ctrl_q[CTRL_TOM_LSB +: 2]);
  assign gen_fn = gen_function_t'(ctrl_q[CTRL_FUNC_LSB +: 2]);

  // The sync enable bit resets to zero, so the pulse stays off after power-on.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      ctrl_q <= CTRL_RESET[CTRL_USED_W-1:0];
    end else if (reg_wr_i && hit(reg_addr_i, OFF_CTRL)) begin
      ctrl_q <= reg_wdata_i[CTRL_USED_W-1:0];
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      sweep_time_q <= SWEEP_TIME_RESET[TIME_W-1:0];
    end else if (reg_wr_i && hit(reg_addr_i, OFF_SWEEP_TIME)) begin
      sweep_time_q <= reg_wdata_i[TIME_W-1:0];
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      dwell_time_q <= DWELL_TIME_RESET[TIME_W-1:0];
    end else if (reg_wr_i && hit(reg_addr_i, OFF_DWELL_TIME)) begin
      dwell_time_q <= reg_wdata_i[TIME_W-1:0];
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      sync_out_en_o <= 1'b0;
    end else begin
      sync_out_en_o <= ctrl_q[CTRL_SYNC_EN_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Trigger input path.

  logic trig_meta_q;
  logic trig_sync_q;
  logic trig_prev_q;
  logic trig_level;
  logic trig_edge;
  logic ext_edge;

  // The meta flop feeds only the second flop; everything downstream uses trig_sync_q.
  always_ff @(posedge clock_i) begin
    trig_meta_q <= trig_pin_i;
    trig_sync_q <= trig_meta_q;
    trig_prev_q <= trig_sync_q;
  end

  // Polarity maps the pin level to a logic value.
  assign trig_level = trig_sync_q ^ pol_negative;

  // Slope picks which raw pin transition counts, independent of polarity.
  assign trig_edge = slope_falling ? (trig_prev_q && !trig_sync_q)
                                   : (!trig_prev_q && trig_sync_q);

  // Edges are only honoured while the port listens to an external source.
  assign ext_edge = trig_edge && !src_internal;

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      trig_event_o <= 1'b0;
    end else begin
      trig_event_o <= ext_edge;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Microsecond tick for the output timers.

  logic [7:0] tick_div_q;
  logic tick;

  assign tick = (tick_div_q == 8'(TICK_CYCLES - 1));

  always_ff @(posedge clock_i) begin
    if (sys_rst_i || tick) begin
      tick_div_q <= 8'h00;
    end else begin
      tick_div_q <= tick_div_q + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Trigger output value.

  logic [TIME_W-1:0] pulse_left_q;
  logic trig_value;
  logic sweep_load;
  logic seq_load;

  // A start in another function, or with an external source, is ignored.
  assign sweep_load = src_internal && (gen_fn == FN_SWEEP) && sweep_start_i;
  assign seq_load = src_internal && (gen_fn == FN_SEQUENCE) && seq_start_i;

  // A start loads the pulse length; the timer only runs down on ticks, so the
  // length carries up to one tick of phase uncertainty against the start.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      pulse_left_q <= '0;
    end else if (sweep_load) begin
      pulse_left_q <= sweep_time_q >> 1;
    end else if (seq_load) begin
      pulse_left_q <= dwell_time_q;
    end else if (!src_internal || gen_fn == FN_BURST) begin
      pulse_left_q <= '0;
    end else if (tick && pulse_left_q != '0) begin
      pulse_left_q <= pulse_left_q - 1'b1;
    end
  end

  always_comb begin
    case (gen_fn)
      FN_BURST: trig_value = burst_active_i;
      FN_SWEEP: trig_value = (pulse_left_q != '0);
      FN_SEQUENCE: trig_value = (pulse_left_q != '0);
      default: trig_value = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Trigger pin drive.

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      trig_pin_oe_o <= 1'b0;
    end else begin
      trig_pin_oe_o <= src_internal
                       && (out_mode == TOM_RISING || out_mode == TOM_FALLING);
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      trig_pin_o <= 1'b0;
    end else begin
      case (out_mode)
        TOM_RISING: trig_pin_o <= trig_value;
        TOM_FALLING: trig_pin_o <= !trig_value;
        default: trig_pin_o <= 1'b0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Reference detection and selection.

  ref_status_if ref_st ();

  // The lock limits fit the default window; a shorter window needs new limits.
  ref_freq_monitor #(
    .WINDOW_CYCLES(REF_WINDOW),
    .LOCK_MIN(REF_EDGES_NOMINAL - LOCK_TOL_EDGES),
    .LOCK_MAX(REF_EDGES_NOMINAL + LOCK_TOL_EDGES),
    .PRESENT_MIN(PRESENT_MIN_EDGES)
  ) u_mon (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .ref_level_i(reference_clock_input_i),
    .st(ref_st)
  );

  ref_state_t ref_state_q;
  ref_state_t ref_state_d;

  always_comb begin
    ref_state_d = ref_state_q;
    if (ref_st.window_done) begin
      if (!ref_st.present) begin
        ref_state_d = REF_NONE;
      end else if (ref_st.in_range) begin
        ref_state_d = REF_EXT;
      end else begin
        ref_state_d = REF_BAD;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      ref_state_q <= REF_NONE;
    end else begin
      ref_state_q <= ref_state_d;
    end
  end

  // Selection follows the next state so the switch and the flags move together.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      ref_sel_ext_o <= 1'b0;
    end else begin
      ref_sel_ext_o <= (ref_state_d == REF_EXT);
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      ext_ref_active_o <= 1'b0;
      ref_invalid_o <= 1'b0;
      ref_removed_o <= 1'b0;
    end else begin
      ext_ref_active_o <= (ref_state_d == REF_EXT);
      ref_invalid_o <= (ref_state_d == REF_BAD);
      ref_removed_o <= (ref_state_q != REF_NONE) && (ref_state_d == REF_NONE);
    end
  end

  // The internal 10 MHz oscillator buffer is enabled at all times out of reset.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      reference_clock_output_en_o <= 1'b1;
    end else begin
      reference_clock_output_en_o <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sticky status bits: write one to clear, a new event in the same cycle wins.

  logic clr_status;
  logic clr_removed;
  logic clr_edge;
  logic removed_evt;

  assign clr_status = reg_wr_i && hit(reg_addr_i, OFF_STATUS);
  assign clr_removed = clr_status && reg_wdata_i[ST_REMOVED_BIT];
  assign clr_edge = clr_status && reg_wdata_i[ST_TRIG_EDGE_BIT];
  assign removed_evt = (ref_state_q != REF_NONE) && (ref_state_d == REF_NONE);

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      removed_q <= 1'b0;
    end else if (removed_evt) begin
      removed_q <= 1'b1;
    end else if (clr_removed) begin
      removed_q <= 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      edge_seen_q <= 1'b0;
    end else if (ext_edge) begin
      edge_seen_q <= 1'b1;
    end else if (clr_edge) begin
      edge_seen_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read port: data stand one cycle after the strobe and read zero otherwise.

  always_comb begin
    rdata_d = '0;
    if (hit(reg_addr_i, OFF_CTRL)) begin
      rdata_d[CTRL_USED_W-1:0] = ctrl_q;
    end else if (hit(reg_addr_i, OFF_SWEEP_TIME)) begin
      rdata_d[TIME_W-1:0] = sweep_time_q;
    end else if (hit(reg_addr_i, OFF_DWELL_TIME)) begin
      rdata_d[TIME_W-1:0] = dwell_time_q;
    end else if (hit(reg_addr_i, OFF_STATUS)) begin
      rdata_d[ST_EXT_ACTIVE_BIT] = (ref_state_q == REF_EXT);
      rdata_d[ST_INVALID_BIT] = (ref_state_q == REF_BAD);
      rdata_d[ST_REMOVED_BIT] = removed_q;
      rdata_d[ST_TRIG_OUT_BIT] = trig_value;
      rdata_d[ST_TRIG_LEVEL_BIT] = trig_level;
      rdata_d[ST_TRIG_EDGE_BIT] = edge_seen_q;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= '0;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rdata_d;
    end else begin
      reg_rdata_o <= '0;
    end
  end
endmodule
`default_nettype wire

// ==== sim/ref_src_model.sv ====
// Purpose: Far-side reference clock source feeding the reference input.
// Assumes: mode 0 absent, 1 in lock range (10 MHz), 2 present but out of range (5 MHz).
// Notes: Phase offset keeps source edges away from the 25 MHz sampling edges.
`timescale 1ns/1ps
`default_nettype none
module ref_src_model (
  input wire logic [1:0] mode_i,
  output logic ref_o
);
  // An unplugged transformer-coupled input carries no clock, so it rests low.
  initial begin
    ref_o = 1'b0;
    #3;
    forever begin
      if (mode_i == 2'h1) begin
        #50 ref_o = ~ref_o;
      end else if (mode_i == 2'h2) begin
        #100 ref_o = ~ref_o;
      end else begin
        #20 ref_o = 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ==== sim/trig_ref_checker.sv ====
// Purpose: Port-level temporal checks of the trigger and reference block.
// Assumes: Control register is shadowed from the register write port.
// Notes: Output checks wait three edges after a control write to let it settle.
`timescale 1ns/1ps
`default_nettype none
module trig_ref_checker
  import trig_ref_pkg::*;
(
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic burst_active_i,
  input wire logic sweep_start_i,
  input wire logic trig_pin_i,
  input wire logic trig_pin_o,
  input wire logic trig_pin_oe_o,
  input wire logic trig_event_o,
  input wire logic ref_sel_ext_o,
  input wire logic ext_ref_active_o,
  input wire logic ref_invalid_o,
  input wire logic ref_removed_o,
  input wire logic reference_clock_output_en_o,
  input wire logic sync_out_en_o
);
  logic [7:0] ctrl_q;
  logic [1:0] age_q;
  logic ctrl_wr;
  logic calm;

  assign ctrl_wr = reg_wr_i && (reg_addr_i == OFF_CTRL);
  assign calm = (age_q == 2'h3);

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      ctrl_q <= 8'h00;
    end else if (ctrl_wr) begin
      ctrl_q <= reg_wdata_i[7:0];
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i || ctrl_wr) begin
      age_q <= 2'h0;
    end else if (age_q != 2'h3) begin
      age_q <= age_q + 2'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  property p_ref_out;
    reference_clock_output_en_o;
  endproperty
  a_ref_out: assert property (p_ref_out) else $error("ref output off");

  property p_sync_off;
    $rose(sync_out_en_o) |-> $past(ctrl_wr && reg_wdata_i[7], 2);
  endproperty
  a_sync_off: assert property (p_sync_off) else $error("sync on unasked");

  property p_ext_no_oe;
    calm && !ctrl_q[0] |-> !trig_pin_oe_o;
  endproperty
  a_ext_no_oe: assert property (p_ext_no_oe) else $error("pin driven ext");

  property p_closed;
    calm && ctrl_q[4:3] == 2'h0 |-> !trig_pin_oe_o;
  endproperty
  a_closed: assert property (p_closed) else $error("closed mode drives");

  property p_ev_one;
    trig_event_o |=> !trig_event_o;
  endproperty
  a_ev_one: assert property (p_ev_one) else $error("event too long");

  property p_ev_edge;
    trig_event_o |-> $past(trig_pin_i, 3) != ctrl_q[2] && $past(trig_pin_i, 4) == ctrl_q[2];
  endproperty
  a_ev_edge: assert property (p_ev_edge) else $error("event wrong edge");

  property p_burst;
    calm && ctrl_q[6:0] == 7'h09 |-> trig_pin_oe_o && trig_pin_o == $past(burst_active_i);
  endproperty
  a_burst: assert property (p_burst) else $error("burst value");

  property p_fall;
    calm && ctrl_q[6:0] == 7'h11 |-> trig_pin_oe_o && trig_pin_o != $past(burst_active_i);
  endproperty
  a_fall: assert property (p_fall) else $error("falling drive");

  property p_sweep;
    calm && ctrl_q[6:0] == 7'h29 && sweep_start_i |-> ##[2:3] trig_pin_o;
  endproperty
  a_sweep: assert property (p_sweep) else $error("sweep no start");

  property p_removed;
    ref_removed_o |-> !ext_ref_active_o && !ref_sel_ext_o ##1 !ref_removed_o;
  endproperty
  a_removed: assert property (p_removed) else $error("removal state");

  property p_invalid;
    ref_invalid_o |-> !ref_sel_ext_o && !ext_ref_active_o;
  endproperty
  a_invalid: assert property (p_invalid) else $error("invalid ref used");
endmodule

bind trig_ref_top trig_ref_checker u_chk (.clock_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i,
  .reg_wr_i, .burst_active_i, .sweep_start_i, .trig_pin_i, .trig_pin_o, .trig_pin_oe_o,
  .trig_event_o, .ref_sel_ext_o, .ext_ref_active_o, .ref_invalid_o, .ref_removed_o,
  .reference_clock_output_en_o, .sync_out_en_o);
`default_nettype wire

// ==== sim/tb_trigger_port_and_ref_select.sv ====
// Purpose: Self-checking bench for the trigger port and reference select block.
// Assumes: Default 2500-cycle reference window; times in 1 us ticks of 25 cycles.
// Notes: Read results are checked by a monitor against a queue of expected words.
`timescale 1ns/1ps
`default_nettype none
module tb_trigger_port_and_ref_select;
  import trig_ref_pkg::*;
  localparam int WIN = REF_WINDOW_CYCLES;
  logic clock_i, sys_rst_i, reg_wr_i, reg_rd_i, burst_active_i, sweep_start_i;
  logic seq_start_i, trig_pin_i, reference_clock_input_i, trig_pin_o, trig_pin_oe_o;
  logic trig_event_o, ref_sel_ext_o, ext_ref_active_o, ref_invalid_o, ref_removed_o;
  logic reference_clock_output_en_o, sync_out_en_o, rd_p, p;
  logic [3:0] reg_addr_i;
  logic [31:0] reg_wdata_i, reg_rdata_o;
  logic [1:0] rmode;
  logic [31:0] exp_q[$], msk_q[$];
  int fails = 0, tests_run = 0, ev_n = 0, rm_n = 0, n0, w, hi;
  int unsigned seed;

  trig_ref_top dut (.clock_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .burst_active_i, .sweep_start_i, .seq_start_i, .trig_pin_i, .trig_pin_o,
    .trig_pin_oe_o, .trig_event_o, .reference_clock_input_i, .ref_sel_ext_o,
    .ext_ref_active_o, .ref_invalid_o, .ref_removed_o, .reference_clock_output_en_o,
    .sync_out_en_o);
  ref_src_model ref_src (.mode_i(rmode), .ref_o(reference_clock_input_i));

  always #20 clock_i = ~clock_i;

  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clock_i);
    reg_wr_i <= 1'b0;
    @(posedge clock_i);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clock_i);
    reg_rd_i <= 1'b0;
    @(posedge clock_i);
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Read data stand only in the cycle after the strobe, so compare exactly there.
  always @(posedge clock_i) begin
    if (rd_p && exp_q.size() > 0) begin
      chk("reg_rdata", exp_q.pop_front(), reg_rdata_o & msk_q.pop_front());
    end
    rd_p <= reg_rd_i;
    if (trig_event_o === 1'b1) ev_n++;
    if (ref_removed_o === 1'b1) rm_n++;
  end

  initial begin
    repeat (40_000) @(posedge clock_i);
    fails++;
    give_verdict();
  end

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    {clock_i, reg_wr_i, reg_rd_i, burst_active_i, sweep_start_i, seq_start_i, rd_p} = '0;
    {trig_pin_i, reg_addr_i, reg_wdata_i, rmode} = '0;
    sys_rst_i = 1'b1;
    seed = $urandom(32'h0000_f040);
    repeat (10) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    @(posedge clock_i);
    rd(OFF_CTRL, CTRL_RESET, '1);
    rd(OFF_SWEEP_TIME, SWEEP_TIME_RESET, '1);
    rd(OFF_DWELL_TIME, DWELL_TIME_RESET, '1);
    rd(4'h1, 32'h0000_0000, '1);
    chk("sync_en", 0, sync_out_en_o);
    chk("ref_out_en", 1, reference_clock_output_en_o);
    $display("test reset done");

    for (int c = 0; c < 4; c++) begin
      p = 1'($urandom());
      trig_pin_i <= p;
      wr(OFF_CTRL, 32'(2 * c));
      repeat (6) @(posedge clock_i);
      for (int k = 0; k < 2; k++) begin
        n0 = ev_n;
        p = ~p;
        trig_pin_i <= p;
        repeat (8) @(posedge clock_i);
        chk("trig_event", 32'(p == !c[1]), ev_n - n0);
        rd(OFF_STATUS, 32'(p ^ c[0]) << 4, 32'h0000_0010);
      end
    end
    chk("trig_oe", 0, trig_pin_oe_o);
    rd(OFF_STATUS, 32'h0000_0020, 32'h0000_0020);
    wr(OFF_STATUS, 32'h0000_0020);
    rd(OFF_STATUS, 32'h0000_0000, 32'h0000_0020);
    $display("test trigger input done");

    for (int m = 0; m < 3; m++) begin
      wr(OFF_CTRL, 32'(1 + 8 * m));
      for (int b = 0; b < 2; b++) begin
        burst_active_i <= b[0];
        repeat (4) @(posedge clock_i);
        chk("trig_oe", 32'(m != 0), trig_pin_oe_o);
        if (m != 0) chk("trig_pin", 32'(b[0] ^ (m == 2)), trig_pin_o);
        if (m == 0) rd(OFF_STATUS, 32'(b) << 3, 32'h0000_0008);
      end
    end
    burst_active_i <= 1'b0;
    $display("test trigger output done");

    wr(OFF_SWEEP_TIME, 32'h0000_0006);
    wr(OFF_DWELL_TIME, 32'h0000_0002);
    for (int f = 1; f < 3; f++) begin
      wr(OFF_CTRL, 32'(9 + 32 * f));
      repeat (4) @(posedge clock_i);
      sweep_start_i <= (f == 1);
      seq_start_i <= (f == 2);
      @(posedge clock_i);
      {sweep_start_i, seq_start_i} <= 2'b00;
      w = 0;
      repeat (150) begin
        @(posedge clock_i);
        if (trig_pin_o === 1'b1) w++;
      end
      hi = (f == 1) ? 75 : 50;
      chk("pulse_len_ok", 1, 32'(w >= hi - 26 && w <= hi + 1));
    end
    $display("test sweep and sequence done");

    wr(OFF_CTRL, 32'h0000_0080);
    @(posedge clock_i);
    chk("sync_en", 1, sync_out_en_o);
    rd(OFF_CTRL, 32'h0000_0080, '1);
    $display("test sync enable done");

    rmode <= 2'h1;
    repeat (3 * WIN) @(posedge clock_i);
    chk("ref_sel", 1, ref_sel_ext_o);
    rd(OFF_STATUS, 32'h0000_0001, 32'h0000_0003);
    rmode <= 2'h2;
    repeat (3 * WIN) @(posedge clock_i);
    chk("ref_sel", 0, ref_sel_ext_o);
    chk("ref_invalid", 1, ref_invalid_o);
    rmode <= 2'h1;
    repeat (3 * WIN) @(posedge clock_i);
    chk("ref_sel", 1, ref_sel_ext_o);
    n0 = rm_n;
    rmode <= 2'h0;
    repeat (3 * WIN) @(posedge clock_i);
    chk("removed_pulses", 1, rm_n - n0);
    chk("ext_active", 0, ext_ref_active_o);
    rd(OFF_STATUS, 32'h0000_0004, 32'h0000_0007);
    wr(OFF_STATUS, 32'h0000_0004);
    rd(OFF_STATUS, 32'h0000_0000, 32'h0000_0004);
    $display("test reference done");
    give_verdict();
  end
endmodule
`default_nettype wire
